// file: rtl/cigr_defines.vh
// register indices, field positions, reset values and timing for the config bank
`ifndef CIGR_DEFINES_VH
`define CIGR_DEFINES_VH

// ----------------------------------------------------------------
// configuration index values
// ----------------------------------------------------------------
`define CIGR_IDX_IRQ1_MODE 8'h29
`define CIGR_IDX_IRQ_MAP23 8'h2A
`define CIGR_IDX_FIR_BASE 8'h2B
`define CIGR_IDX_FIR_DMA 8'h2C
`define CIGR_IDX_TIMEOUT 8'h2D
`define CIGR_IDX_SS_A 8'h2E
`define CIGR_IDX_SS_B 8'h2F
`define CIGR_IDX_RT_BASE 8'h30
`define CIGR_IDX_GP_DIR1 8'h31
`define CIGR_IDX_GP_POL1 8'h32
`define CIGR_IDX_GP_DIR2 8'h33
`define CIGR_IDX_GP_POL2 8'h34
`define CIGR_IDX_GP_DIR3 8'h35
`define CIGR_IDX_GP_POL3 8'h36

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIGR_RST_IRQ1_MODE 8'h80
`define CIGR_RST_IRQ_MAP23 8'h00
`define CIGR_RST_FIR_BASE 8'h00
`define CIGR_RST_FIR_DMA 8'h0F
`define CIGR_RST_TIMEOUT 8'h03
`define CIGR_RST_SS 8'h00
`define CIGR_RST_RT_BASE 8'h00
`define CIGR_RST_GPIO 8'h00
`define CIGR_RST_INDEX 8'h00

// ----------------------------------------------------------------
// writable-bit masks
// ----------------------------------------------------------------
`define CIGR_WM_IRQ1_MODE 8'h9F
`define CIGR_WM_FIR_DMA 8'h0F
`define CIGR_WM_RT_BASE 8'hFE
`define CIGR_WM_GP_DIR2 8'h0F
`define CIGR_WM_GP_POL2 8'h2F
`define CIGR_WM_FULL 8'hFF

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define CIGR_BIT_ROUTE_SEL 4
`define CIGR_BIT_SIRQ_EN 7
`define CIGR_BIT_WAKE_POL 5
`define CIGR_DMA_NONE 4'hF
`define CIGR_DMA_LAST 4'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CIGR_CLK_PERIOD_NS 25
`define CIGR_TO_UNIT_NS 100000

`endif

// file: rtl/cigr_irq_route.v
// routes one synchronised interrupt input onto a 16-line irq vector
`timescale 1ns/1ps
`default_nettype none
module cigr_irq_route (
  input wire irq_level, // synchronised input level
  input wire [3:0] irq_sel, // irq number, 0 = no output
  output reg [15:0] irq_vec // one-hot routed request
);
  always @* begin
    irq_vec = 16'h0000;
    if (irq_sel != 4'h0) begin
      irq_vec[irq_sel] = irq_level;
    end
  end
endmodule // cigr_irq_route
`default_nettype wire

// file: rtl/cigr_gpio_bank.v
// direction and polarity pin logic for one 8-bit gpio group
`timescale 1ns/1ps
`default_nettype none
module cigr_gpio_bank (
  input wire clk, // system clock
  input wire stby_reset, // standby-supply reset, active high
  input wire [7:0] pin_in, // pin levels, asynchronous
  input wire [7:0] dir, // direction register
  input wire [7:0] pol, // polarity register
  input wire [7:0] core_out, // value the logic drives
  output reg [7:0] pin_out, // pin drive value
  output reg [7:0] pin_oe, // pin output enable
  output reg [7:0] core_in // pin value seen by the logic
);
  reg [7:0] meta_reg;
  reg [7:0] sync_reg;

  always @(posedge clk or posedge stby_reset) begin
    if (stby_reset) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      core_in <= 8'h00;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      pin_oe <= dir;
      pin_out <= core_out ^ pol;
      core_in <= sync_reg ^ pol;
    end
  end
endmodule // cigr_gpio_bank
`default_nettype wire

// file: rtl/cigr_regs.v
// configuration register bank: irq routing, infrared, runtime base, gpio
`timescale 1ns/1ps
`default_nettype none
`include "cigr_defines.vh"
module cigr_regs (
  input wire clk, // 40 MHz system clock
  input wire reset, // main-supply reset, async, active high
  input wire stby_reset, // standby-supply reset, async, active high
  input wire config_mode, // device is in configuration state
  input wire cfg_index_wr, // pulse: write config index
  input wire cfg_data_wr, // pulse: write indexed register
  input wire cfg_data_rd, // pulse: read indexed register
  input wire [7:0] cfg_wdata, // write data for index or register
  output reg [7:0] cfg_rdata, // read data
  output reg cfg_rvalid, // pulse: cfg_rdata valid
  input wire io_valid, // pulse: host io cycle address valid
  input wire [15:0] io_addr, // host io address
  output reg fir_hit, // pulse: io cycle hits infrared engine
  output reg [2:0] fir_reg_sel, // register within the engine
  output reg rt_hit, // pulse: io cycle hits runtime block
  output reg [4:0] rt_offset, // offset within runtime block
  output reg wake_status_sel, // pulse: runtime offset zero
  input wire ext_irq_input_one, // external interrupt pin one
  input wire ext_irq_input_two, // external interrupt pin two
  input wire ext_irq_input_three, // external interrupt pin three
  output reg [15:0] irq_out, // routed irq lines, bit 0 unused
  output reg ir_receive_route_select, // 1 = third receive input
  output reg serial_irq_clock_run_enable, // serial irq and clock run on
  input wire fir_dma_req, // dma request from infrared engine
  output reg [3:0] dma_request_output, // dma request drive values
  output reg [3:0] dma_request_output_oe, // dma request enables
  input wire ir_to_wr, // pulse: engine io write of timeout
  input wire [7:0] ir_to_wdata, // engine timeout write data
  input wire ir_soft_reset, // engine software reset
  input wire ir_ss_wr_a, // pulse: engine write of soft select a
  input wire ir_ss_wr_b, // pulse: engine write of soft select b
  input wire [7:0] ir_ss_wdata, // engine soft select write data
  output wire [7:0] ir_timeout_val, // shared timeout value
  output wire [7:0] ir_ss_a, // shared soft select a
  output wire [7:0] ir_ss_b, // shared soft select b
  input wire ta_start, // pulse: start turnaround delay
  output reg ta_busy, // turnaround delay running
  input wire [7:0] gp1_in, // group one pins in
  output wire [7:0] gp1_out, // group one pin drive
  output wire [7:0] gp1_oe, // group one pin enable
  input wire [7:0] gp1_core_out, // group one logic value out
  output wire [7:0] gp1_core_in, // group one logic value in
  input wire [7:0] gp2_in, // group two pins in
  output wire [7:0] gp2_out, // group two pin drive
  output wire [7:0] gp2_oe, // group two pin enable
  input wire [7:0] gp2_core_out, // group two logic value out
  output wire [7:0] gp2_core_in, // group two logic value in
  input wire [7:0] gp3_in, // group three pins in
  output wire [7:0] gp3_out, // group three pin drive
  output wire [7:0] gp3_oe, // group three pin enable
  input wire [7:0] gp3_core_out, // group three logic value out
  output wire [7:0] gp3_core_in, // group three logic value in
  input wire wake_event, // wake event asserted by logic
  output reg wake_event_output_pin // wake pin drive
);

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam integer TO_UNIT_CYC_I = `CIGR_TO_UNIT_NS / `CIGR_CLK_PERIOD_NS;
  localparam [11:0] TO_UNIT_CYC = TO_UNIT_CYC_I[11:0];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0] index_reg;
  reg [7:0] mode_reg;
  reg [7:0] map23_reg;
  reg [7:0] fir_base_reg;
  reg [7:0] dma_sel_reg;
  reg [7:0] timeout_reg;
  reg [7:0] ss_a_reg;
  reg [7:0] ss_b_reg;
  reg [7:0] rt_base_reg;
  reg [7:0] dir1_reg;
  reg [7:0] pol1_reg;
  reg [7:0] dir2_reg;
  reg [7:0] pol2_reg;
  reg [7:0] dir3_reg;
  reg [7:0] pol3_reg;
  reg [7:0] rdata_next;
  reg [2:0] irq1_sync_reg;
  reg [2:0] irq2_sync_reg;
  wire [15:0] vec1;
  wire [15:0] vec2;
  wire [15:0] vec3;
  wire cfg_wr;
  wire fir_enabled;
  wire rt_enabled;
  reg [11:0] tick_cnt_reg;
  reg [7:0] unit_cnt_reg;

  assign cfg_wr = config_mode & cfg_data_wr;
  assign ir_timeout_val = timeout_reg;
  assign ir_ss_a = ss_a_reg;
  assign ir_ss_b = ss_b_reg;

  // ----------------------------------------------------------------
  // config index
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      index_reg <= `CIGR_RST_INDEX;
    end else if (config_mode && cfg_index_wr) begin
      index_reg <= cfg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // main-supply registers
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= `CIGR_RST_IRQ1_MODE;
      map23_reg <= `CIGR_RST_IRQ_MAP23;
      fir_base_reg <= `CIGR_RST_FIR_BASE;
      dma_sel_reg <= `CIGR_RST_FIR_DMA;
      rt_base_reg <= `CIGR_RST_RT_BASE;
    end else if (cfg_wr) begin
      case (index_reg)
        `CIGR_IDX_IRQ1_MODE: begin
          mode_reg <= cfg_wdata & `CIGR_WM_IRQ1_MODE;
        end
        `CIGR_IDX_IRQ_MAP23: begin
          map23_reg <= cfg_wdata;
        end
        `CIGR_IDX_FIR_BASE: begin
          fir_base_reg <= cfg_wdata;
        end
        `CIGR_IDX_FIR_DMA: begin
          dma_sel_reg <= cfg_wdata & `CIGR_WM_FIR_DMA;
        end
        `CIGR_IDX_RT_BASE: begin
          rt_base_reg <= cfg_wdata & `CIGR_WM_RT_BASE;
        end
        default: begin
          mode_reg <= mode_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers shared with the infrared engine
  // ----------------------------------------------------------------
  // the engine soft reset is deliberately not wired in here: the shared
  // values only follow explicit writes and power-on reset
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      timeout_reg <= `CIGR_RST_TIMEOUT;
      ss_a_reg <= `CIGR_RST_SS;
      ss_b_reg <= `CIGR_RST_SS;
    end else begin
      // engine write wins a same-cycle collision with the config path
      if (ir_to_wr) begin
        timeout_reg <= ir_to_wdata;
      end else if (cfg_wr && index_reg == `CIGR_IDX_TIMEOUT) begin
        timeout_reg <= cfg_wdata;
      end
      if (ir_ss_wr_a) begin
        ss_a_reg <= ir_ss_wdata;
      end else if (cfg_wr && index_reg == `CIGR_IDX_SS_A) begin
        ss_a_reg <= cfg_wdata;
      end
      if (ir_ss_wr_b) begin
        ss_b_reg <= ir_ss_wdata;
      end else if (cfg_wr && index_reg == `CIGR_IDX_SS_B) begin
        ss_b_reg <= cfg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // standby-supply gpio registers
  // ----------------------------------------------------------------
  always @(posedge clk or posedge stby_reset) begin
    if (stby_reset) begin
      dir1_reg <= `CIGR_RST_GPIO;
      pol1_reg <= `CIGR_RST_GPIO;
      dir2_reg <= `CIGR_RST_GPIO;
      pol2_reg <= `CIGR_RST_GPIO;
      dir3_reg <= `CIGR_RST_GPIO;
      pol3_reg <= `CIGR_RST_GPIO;
    end else if (cfg_wr) begin
      case (index_reg)
        `CIGR_IDX_GP_DIR1: begin
          dir1_reg <= cfg_wdata & `CIGR_WM_FULL;
        end
        `CIGR_IDX_GP_POL1: begin
          pol1_reg <= cfg_wdata & `CIGR_WM_FULL;
        end
        `CIGR_IDX_GP_DIR2: begin
          dir2_reg <= cfg_wdata & `CIGR_WM_GP_DIR2;
        end
        `CIGR_IDX_GP_POL2: begin
          pol2_reg <= cfg_wdata & `CIGR_WM_GP_POL2;
        end
        `CIGR_IDX_GP_DIR3: begin
          dir3_reg <= cfg_wdata & `CIGR_WM_FULL;
        end
        `CIGR_IDX_GP_POL3: begin
          pol3_reg <= cfg_wdata & `CIGR_WM_FULL;
        end
        default: begin
          dir1_reg <= dir1_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always @* begin
    case (index_reg)
      `CIGR_IDX_IRQ1_MODE: rdata_next = mode_reg;
      `CIGR_IDX_IRQ_MAP23: rdata_next = map23_reg;
      `CIGR_IDX_FIR_BASE: rdata_next = fir_base_reg;
      `CIGR_IDX_FIR_DMA: rdata_next = dma_sel_reg;
      `CIGR_IDX_TIMEOUT: rdata_next = timeout_reg;
      `CIGR_IDX_SS_A: rdata_next = ss_a_reg;
      `CIGR_IDX_SS_B: rdata_next = ss_b_reg;
      `CIGR_IDX_RT_BASE: rdata_next = rt_base_reg;
      `CIGR_IDX_GP_DIR1: rdata_next = dir1_reg;
      `CIGR_IDX_GP_POL1: rdata_next = pol1_reg;
      `CIGR_IDX_GP_DIR2: rdata_next = dir2_reg;
      `CIGR_IDX_GP_POL2: rdata_next = pol2_reg;
      `CIGR_IDX_GP_DIR3: rdata_next = dir3_reg;
      `CIGR_IDX_GP_POL3: rdata_next = pol3_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_data_rd;
      if (cfg_data_rd) begin
        // outside the configuration state a read answers zero
        cfg_rdata <= config_mode ? rdata_next : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // io address decode
  // ----------------------------------------------------------------
  assign fir_enabled = (fir_base_reg[7:5] != 3'h0);
  assign rt_enabled = (rt_base_reg[7:4] != 4'h0);

  // decode uses the registers as they stand, so a write is seen from the
  // io cycle after it completes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fir_hit <= 1'b0;
      fir_reg_sel <= 3'h0;
      rt_hit <= 1'b0;
      rt_offset <= 5'h00;
      wake_status_sel <= 1'b0;
    end else begin
      fir_hit <= io_valid && fir_enabled && (io_addr[15:11] == 5'h00)
                 && (io_addr[10:3] == fir_base_reg);
      fir_reg_sel <= io_addr[2:0];
      rt_hit <= io_valid && rt_enabled && (io_addr[15:12] == 4'h0)
                && (io_addr[11:5] == rt_base_reg[7:1]);
      rt_offset <= io_addr[4:0];
      wake_status_sel <= io_valid && rt_enabled && (io_addr[15:12] == 4'h0)
                         && (io_addr[11:5] == rt_base_reg[7:1])
                         && (io_addr[4:0] == 5'h00);
    end
  end

  // ----------------------------------------------------------------
  // irq routing
  // ----------------------------------------------------------------
  // pins are asynchronous: two flops each, only the second stage is read
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irq1_sync_reg <= 3'h0;
      irq2_sync_reg <= 3'h0;
    end else begin
      irq1_sync_reg <= {ext_irq_input_three, ext_irq_input_two,
                        ext_irq_input_one};
      irq2_sync_reg <= irq1_sync_reg;
    end
  end

  cigr_irq_route u_route1 (
    .irq_level(irq2_sync_reg[0]),
    .irq_sel(mode_reg[3:0]),
    .irq_vec(vec1)
  );

  cigr_irq_route u_route2 (
    .irq_level(irq2_sync_reg[1]),
    .irq_sel(map23_reg[3:0]),
    .irq_vec(vec2)
  );

  cigr_irq_route u_route3 (
    .irq_level(irq2_sync_reg[2]),
    .irq_sel(map23_reg[7:4]),
    .irq_vec(vec3)
  );

  // ----------------------------------------------------------------
  // mode outputs, dma and wake pin
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_out <= 16'h0000;
      ir_receive_route_select <= 1'b0;
      serial_irq_clock_run_enable <= 1'b1;
      dma_request_output <= 4'h0;
      dma_request_output_oe <= 4'h0;
    end else begin
      // sharing one irq number between inputs is a software error; the
      // lines simply or together here
      irq_out <= vec1 | vec2 | vec3;
      ir_receive_route_select <= mode_reg[`CIGR_BIT_ROUTE_SEL];
      serial_irq_clock_run_enable <= mode_reg[`CIGR_BIT_SIRQ_EN];
      dma_request_output <= 4'h0;
      dma_request_output_oe <= 4'h0;
      if (dma_sel_reg[3:0] <= `CIGR_DMA_LAST) begin
        dma_request_output[dma_sel_reg[1:0]] <= fir_dma_req;
        dma_request_output_oe[dma_sel_reg[1:0]] <= 1'b1;
      end
    end
  end

  always @(posedge clk or posedge stby_reset) begin
    if (stby_reset) begin
      wake_event_output_pin <= 1'b1;
    end else begin
      // non-inverted polarity drives the pin low while the event is on
      wake_event_output_pin <= ~(wake_event ^ pol2_reg[`CIGR_BIT_WAKE_POL]);
    end
  end

  // ----------------------------------------------------------------
  // half-duplex turnaround delay
  // ----------------------------------------------------------------
  // a value of zero gives no delay at all: ta_busy never rises
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ta_busy <= 1'b0;
      tick_cnt_reg <= 12'h000;
      unit_cnt_reg <= 8'h00;
    end else if (ta_start) begin
      ta_busy <= (timeout_reg != 8'h00);
      tick_cnt_reg <= 12'h000;
      unit_cnt_reg <= timeout_reg;
    end else if (ta_busy) begin
      if (tick_cnt_reg == TO_UNIT_CYC - 12'h001) begin
        tick_cnt_reg <= 12'h000;
        unit_cnt_reg <= unit_cnt_reg - 8'h01;
        if (unit_cnt_reg == 8'h01) begin
          ta_busy <= 1'b0;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // gpio groups
  // ----------------------------------------------------------------
  cigr_gpio_bank u_gp1 (
    .clk(clk),
    .stby_reset(stby_reset),
    .pin_in(gp1_in),
    .dir(dir1_reg),
    .pol(pol1_reg),
    .core_out(gp1_core_out),
    .pin_out(gp1_out),
    .pin_oe(gp1_oe),
    .core_in(gp1_core_in)
  );

  cigr_gpio_bank u_gp2 (
    .clk(clk),
    .stby_reset(stby_reset),
    .pin_in(gp2_in),
    .dir(dir2_reg),
    .pol(pol2_reg),
    .core_out(gp2_core_out),
    .pin_out(gp2_out),
    .pin_oe(gp2_oe),
    .core_in(gp2_core_in)
  );

  cigr_gpio_bank u_gp3 (
    .clk(clk),
    .stby_reset(stby_reset),
    .pin_in(gp3_in),
    .dir(dir3_reg),
    .pol(pol3_reg),
    .core_out(gp3_core_out),
    .pin_out(gp3_out),
    .pin_oe(gp3_oe),
    .core_in(gp3_core_in)
  );

endmodule // cigr_regs
`default_nettype wire

// file: test/cigr_regs_chk.sv
// port assertions for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cigr_regs_chk (
  input wire clk, // clock
  input wire reset, // main reset
  input wire config_mode, // config state
  input wire cfg_index_wr, // index strobe
  input wire cfg_data_wr, // write strobe
  input wire cfg_data_rd, // read strobe
  input wire [7:0] cfg_wdata, // index or data
  input wire [7:0] cfg_rdata, // read data
  input wire cfg_rvalid, // read valid
  input wire io_valid, // io cycle
  input wire [15:0] io_addr, // io address
  input wire fir_hit, // engine hit
  input wire [2:0] fir_reg_sel, // engine reg
  input wire rt_hit, // runtime hit
  input wire [4:0] rt_offset, // runtime offset
  input wire wake_status_sel, // offset zero
  input wire [3:0] dma_request_output_oe, // dma enables
  input wire ir_to_wr, // engine write
  input wire [7:0] ir_to_wdata, // engine data
  input wire ir_soft_reset, // engine soft reset
  input wire [7:0] ir_timeout_val, // shared timeout
  input wire ta_start, // delay start
  input wire ta_busy // delay running
);
  logic [7:0] idx_reg;
  always_ff @(posedge clk or posedge reset)
    if (reset) idx_reg <= 8'h00;
    else if (config_mode && cfg_index_wr) idx_reg <= cfg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (cfg_rvalid == $past(cfg_data_rd))
    else $error("read answer misplaced");
  a_refused_read: assert property (cfg_data_rd && !config_mode |=> cfg_rdata == 8'h00)
    else $error("read outside config state returned data");
  a_mode_fixed: assert property (cfg_rvalid && idx_reg == 8'h29 |-> cfg_rdata[6:5] == 2'b00)
    else $error("mode byte fixed bits set");
  a_dma_upper: assert property (cfg_rvalid && idx_reg == 8'h2C |-> cfg_rdata[7:4] == 4'h0)
    else $error("dma upper nibble set");
  a_dma_single: assert property ($onehot0(dma_request_output_oe))
    else $error("more than one dma request driven");
  a_fir_match: assert property (fir_hit |-> $past(io_valid) && $past(io_addr[15:11]) == 5'h00
    && $past(io_addr[10:8]) != 3'h0 && fir_reg_sel == $past(io_addr[2:0]))
    else $error("engine hit without matching cycle");
  a_rt_match: assert property (rt_hit |-> $past(io_valid) && $past(io_addr[15:12]) == 4'h0
    && $past(io_addr[11:8]) != 4'h0 && rt_offset == $past(io_addr[4:0]))
    else $error("runtime hit without matching cycle");
  a_wake_select: assert property (wake_status_sel |-> rt_hit && rt_offset == 5'h00)
    else $error("wake status select off offset zero");
  a_timeout_mirror: assert property (ir_to_wr |=> ir_timeout_val == $past(ir_to_wdata))
    else $error("engine timeout write lost");
  a_soft_keep: assert property (ir_soft_reset && !ir_to_wr && !cfg_data_wr
    |=> $stable(ir_timeout_val))
    else $error("soft reset changed timeout");
  a_busy_start: assert property ($rose(ta_busy) |-> $past(ta_start))
    else $error("delay started without request");
  c_fir_hit: cover property (fir_hit);
  c_wake_sel: cover property (wake_status_sel);
  c_busy_end: cover property (ta_busy ##1 !ta_busy);
endmodule // cigr_regs_chk
bind cigr_regs cigr_regs_chk chk_i (.*);
`default_nettype wire

// file: test/cigr_host.sv
// host model driving the configuration index and data port
`timescale 1ns/1ps
`default_nettype none
module cigr_host (
  input wire logic clk, // clock
  output var logic config_mode, // config state
  output var logic cfg_index_wr, // index strobe
  output var logic cfg_data_wr, // write strobe
  output var logic cfg_data_rd, // read strobe
  output var logic [7:0] cfg_wdata, // index or data
  input wire logic [7:0] cfg_rdata, // read data
  input wire logic cfg_rvalid // read valid
);
  initial begin
    config_mode = 1'b1;
    {cfg_index_wr, cfg_data_wr, cfg_data_rd} = 3'b000;
    cfg_wdata = 8'h00;
  end
  task mode(input logic m);
    @(posedge clk) config_mode <= m;
  endtask
  // index always goes first, data cycles aim at the last index
  task idx(input logic [7:0] i);
    @(posedge clk);
    cfg_index_wr <= 1'b1;
    cfg_wdata <= i;
    @(posedge clk);
    cfg_index_wr <= 1'b0;
  endtask
  task wr(input logic [7:0] i, d);
    idx(i);
    cfg_data_wr <= 1'b1;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_data_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  task rd(input logic [7:0] i, output logic [7:0] d, output logic v);
    idx(i);
    cfg_data_rd <= 1'b1;
    cfg_wdata <= ~i;
    @(posedge clk);
    cfg_data_rd <= 1'b0;
    @(posedge clk);
    d = cfg_rdata;
    v = cfg_rvalid;
  endtask
endmodule // cigr_host
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, reset = 1'b1, stby_reset = 1'b1, ok;
  logic config_mode, cfg_index_wr, cfg_data_wr, cfg_data_rd, cfg_rvalid;
  logic [7:0] cfg_wdata, cfg_rdata, rd_val, ir_to_wdata = 8'h00, ir_ss_wdata = 8'h00;
  logic io_valid = 1'b0, fir_dma_req = 1'b1, ir_to_wr = 1'b0, ir_soft_reset = 1'b0;
  logic ext_irq_input_one = 1'b0, ext_irq_input_two = 1'b0, ext_irq_input_three = 1'b0;
  logic ir_ss_wr_a = 1'b0, ir_ss_wr_b = 1'b0, ta_start = 1'b0, wake_event = 1'b0;
  logic [15:0] io_addr = 16'h0000, irq_out;
  logic [7:0] gp1_in = 8'h00, gp2_in = 8'h00, gp3_in = 8'h00, gp1_core_out = 8'h00;
  logic [7:0] gp2_core_out = 8'h00, gp3_core_out = 8'h00, ir_timeout_val, ir_ss_a, ir_ss_b;
  logic [7:0] gp1_out, gp1_oe, gp1_core_in, gp2_out, gp2_oe, gp2_core_in;
  logic [7:0] gp3_out, gp3_oe, gp3_core_in;
  logic fir_hit, rt_hit, wake_status_sel, ir_receive_route_select, serial_irq_clock_run_enable;
  logic ta_busy, wake_event_output_pin;
  logic [2:0] fir_reg_sel;
  logic [4:0] rt_offset;
  logic [3:0] dma_request_output, dma_request_output_oe;
  logic [7:0] rstv [14] = '{8'h80, 8'h00, 8'h00, 8'h0F, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wmask [14] = '{8'h9F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFF,
    8'hFF, 8'h0F, 8'h2F, 8'hFF, 8'hFF};
  logic [3:0] dcode [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
  int miscompares = 0, total_checks = 0, cyc = 0, n;
  cigr_regs DUT (.*);
  cigr_host host (.*);
  always #12.5 clk = ~clk;
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task rdc(input logic [7:0] i, e);
    host.rd(i, rd_val, ok);
    chk({7'h00, ok, rd_val}, {8'h01, e});
  endtask
  task settle;
    @(posedge clk);
    #1;
  endtask
  // hit fields are only meaningful while the matching hit is up
  task io(input logic [15:0] a, input logic [10:0] e);
    @(posedge clk);
    io_valid <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_valid <= 1'b0;
    #1 chk({fir_hit, fir_hit ? fir_reg_sel : 3'h0, rt_hit, rt_hit ? rt_offset : 5'h00,
      wake_status_sel}, {5'h00, e});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      $display("BAD %0t run did not finish", $time);
      miscompares++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    stby_reset <= 1'b0;
    for (n = 0; n < 14; n++) rdc(8'(8'h29 + n), rstv[n]);
    for (n = 0; n < 14; n++) begin
      host.wr(8'(8'h29 + n), 8'hFF);
      rdc(8'(8'h29 + n), wmask[n]);
    end
    chk({ir_receive_route_select, serial_irq_clock_run_enable}, 16'h0003);
    host.wr(8'h29, 8'h0A);
    settle;
    chk({ir_receive_route_select, serial_irq_clock_run_enable}, 16'h0000);
    host.wr(8'h2A, 8'h53);
    @(posedge clk) {ext_irq_input_one, ext_irq_input_two} <= 2'b11;
    repeat (4) settle;
    chk(irq_out, 16'h0408);
    @(posedge clk) ext_irq_input_three <= 1'b1;
    repeat (4) settle;
    chk(irq_out, 16'h0428);
    foreach (dcode[k]) begin
      host.wr(8'h2C, {4'h0, dcode[k]});
      settle;
      chk({dma_request_output_oe, dma_request_output},
        dcode[k] < 4 ? 16'(17 << dcode[k]) : 16'h0000);
    end
    host.wr(8'h2B, 8'h20);
    io(16'h0103, {1'b1, 3'h3, 7'h00});
    io(16'h0903, 11'h000);
    host.wr(8'h2B, 8'hFF);
    io(16'h07FD, {1'b1, 3'h5, 7'h00});
    host.wr(8'h2B, 8'h1F);
    io(16'h00FB, 11'h000);
    host.wr(8'h30, 8'h10);
    io(16'h0100, {4'h0, 1'b1, 5'h00, 1'b1});
    io(16'h0105, {4'h0, 1'b1, 5'h05, 1'b0});
    io(16'h1100, 11'h000);
    host.wr(8'h30, 8'h0E);
    io(16'h00E0, 11'h000);
    @(posedge clk) {ir_to_wr, ir_to_wdata} <= {1'b1, 8'h5A};
    @(posedge clk) ir_to_wr <= 1'b0;
    rdc(8'h2D, 8'h5A);
    host.wr(8'h2D, 8'h01);
    settle;
    chk(ir_timeout_val, 16'h0001);
    @(posedge clk) ir_soft_reset <= 1'b1;
    @(posedge clk) ir_soft_reset <= 1'b0;
    settle;
    chk(ir_timeout_val, 16'h0001);
    @(posedge clk) {ir_ss_wr_a, ir_ss_wdata} <= {1'b1, 8'h77};
    @(posedge clk) {ir_ss_wr_a, ir_ss_wr_b, ir_ss_wdata} <= {2'b01, 8'h66};
    @(posedge clk) ir_ss_wr_b <= 1'b0;
    rdc(8'h2E, 8'h77);
    rdc(8'h2F, 8'h66);
    host.wr(8'h2E, 8'h3C);
    settle;
    chk({ir_ss_a, ir_ss_b}, 16'h3C66);
    host.mode(1'b0);
    host.wr(8'h2E, 8'h99);
    rdc(8'h2E, 8'h00);
    host.mode(1'b1);
    rdc(8'h2E, 8'h3C);
    @(posedge clk) ta_start <= 1'b1;
    @(posedge clk) ta_start <= 1'b0;
    #1 n = 0;
    while (ta_busy === 1'b1 && n < 5000) begin
      settle;
      n++;
    end
    chk(16'(n), 16'hFA0);
    @(posedge clk) stby_reset <= 1'b1;
    @(posedge clk) stby_reset <= 1'b0;
    rdc(8'h31, 8'h00);
    rdc(8'h2A, 8'h53);
    host.wr(8'h31, 8'h02);
    @(posedge clk) gp1_core_out <= 8'h02;
    settle;
    chk({gp1_oe, gp1_out}, 16'h0202);
    host.wr(8'h36, 8'hFF);
    @(posedge clk) {gp3_in, wake_event} <= {8'h5A, 1'b1};
    repeat (4) settle;
    chk({gp3_core_in, 7'h00, wake_event_output_pin}, 16'hA500);
    host.wr(8'h34, 8'h20);
    settle;
    chk(wake_event_output_pin, 16'h0001);
    end_sim;
  end
endmodule // testbench
`default_nettype wire
